// file: src/esl_regs.svh
// register offsets, field positions, link codes and timing constants
`ifndef ESL_REGS_SVH
`define ESL_REGS_SVH
`define ESL_CLK_NS 8
`define ESL_MS_NS 1000000
`define ESL_LT_END 8'h00
`define ESL_LT_SYNC 8'h43
`define ESL_LT_MS 8'h44
`define ESL_LT_TICK 8'h64
`define ESL_SEL_DEFAULT 8'h00
`define ESL_CMD_NONE 8'h00
`define ESL_OFF_CTRL 13'h0000
`define ESL_OFF_EXT 13'h0004
`define ESL_OFF_RUN 13'h0008
`define ESL_OFF_AXIS 13'h0100
`define ESL_OFF_AXIS_END 13'h0120
`define ESL_OFF_TABLE 13'h0400
`define ESL_OFF_TABLE_END 13'h1400
`define ESL_FLD_CMD 2'h0
`define ESL_FLD_LINK 2'h1
`define ESL_FLD_VAL 2'h2
`define ESL_CTRL_AXIS 2:0
`define ESL_CTRL_STOP 4
`define ESL_CTRL_STEP 15:8
`define ESL_CTRL_GO 31
`define ESL_EXT_AXIS 2:0
`define ESL_EXT_VAL 31:16
`define ESL_RESP_OKAY 2'h0
`define ESL_RESP_SLVERR 2'h2
`endif

// file: src/esl_pkg.sv
// types shared by the step sequencer and its step memory
package esl_pkg;
	typedef struct packed {
		logic [15:0] cmd;
		logic [7:0] ltype;
		logic [7:0] lnext;
		logic [15:0] lval;
	} esl_step_s;
	typedef struct packed {
		logic [7:0] axes;
		logic [7:0] code;
	} esl_cmd_s;
	typedef enum logic [2:0] {
		ESL_IDLE = 3'b001,
		ESL_FETCH = 3'b010,
		ESL_EVAL = 3'b100
	} esl_seq_e;
endpackage

// file: src/esl_step_mem.sv
// step table memory, one array per 16-bit field, registered read
`timescale 1ns/10ps
`default_nettype none
module esl_step_mem #(
	parameter int DEPTH = 256
) (
	// clock
	input wire logic aclk,
	// access
	input wire logic [7:0] addr,
	input wire logic [2:0] fwe,
	input wire logic [15:0] wdata,
	output esl_pkg::esl_step_s rdata
);
	logic [15:0] rd_q [3];
	genvar f;
	generate
		for (f = 0; f < 3; f++) begin : g_fld
			logic [15:0] mem [DEPTH];
			always_ff @(posedge aclk) begin
				if (fwe[f]) begin
					mem[addr] <= wdata;
				end
				rd_q[f] <= mem[addr];
			end
		end
	endgenerate
	assign rdata = {rd_q[0], rd_q[1], rd_q[2]};
endmodule
`default_nettype wire

// file: src/esl_sequencer.sv
// per-axis event step sequencer with axi4-lite register access
// Overview of operation
// - each step names any next step 0..255; taken once its link condition holds
// - default axis selection sends the step command only to the executing axis
// - explicit axis selection sends the step command to every selected axis
// - axis selection lives in the upper byte of the command word
// - link code 0x00 ends the sequence until restarted; its value is zero
// - link code 0x43 is the master sync trigger, unsigned value 0..65535
// - one extended link value per axis, cleared to zero at reset
// - trigger with value equal to extended value waits on the step
// - trigger with differing value copies it to extended value and jumps
// - code 0x44 is millisecond delay, 0x64 counter tick delay, 0..65535
// - millisecond delay starts on step entry, links after value ms elapse
// - millisecond delay of zero links immediately
// - tick delay with counter enabled waits the programmed tick count
// - delays restart on re-entry, so they cannot be polled repeatedly
// - link type and next step appear together as one 16-bit register
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "esl_regs.svh"
module esl_sequencer #(
	parameter int NAX = 8,
	parameter int MS_CYCLES = `ESL_MS_NS / `ESL_CLK_NS
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [12:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [12:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// counter pins
	input wire logic cnt_tick_pin,
	input wire logic cnt_enable_pin,
	// step commands and state
	output logic cmd_valid,
	output esl_pkg::esl_cmd_s cmd_out,
	output logic [NAX-1:0] running
);
	localparam int TCW = $clog2(MS_CYCLES);
	localparam int AW = $clog2(NAX);

	function automatic logic tbl_hit(input logic [12:0] a);
		return a >= `ESL_OFF_TABLE && a < `ESL_OFF_TABLE_END;
	endfunction
	function automatic logic [7:0] onehot8(input logic [AW-1:0] a);
		return 8'(9'h001 << a);
	endfunction
	// bus offset to step index; the table base is not a multiple of the table size
	function automatic logic [7:0] tbl_step(input logic [12:0] a);
		logic [12:0] off;
		off = a - `ESL_OFF_TABLE;
		return off[11:4];
	endfunction

	// pin synchronisers and time bases
	logic [1:0] tk_s_r, en_s_r;
	logic tk_d_r;
	logic [TCW-1:0] tc_r, tc_nxt;
	logic tick_r, tick_nxt;
	logic [15:0] ms_now_r, ms_now_nxt, ticks_r, ticks_nxt;
	always_comb begin
		tc_nxt = tc_r + TCW'(1);
		tick_nxt = 1'b0;
		ms_now_nxt = ms_now_r;
		ticks_nxt = ticks_r;
		if (tc_r == TCW'(MS_CYCLES - 1)) begin
			tc_nxt = '0;
			tick_nxt = 1'b1;
		end
		if (tick_r) begin
			ms_now_nxt = ms_now_r + 16'h0001;
		end
		if (en_s_r[1] && tk_s_r[1] && !tk_d_r) begin
			ticks_nxt = ticks_r + 16'h0001;
		end
	end
	always_ff @(posedge aclk) begin
		tk_s_r <= {tk_s_r[0], cnt_tick_pin};
		en_s_r <= {en_s_r[0], cnt_enable_pin};
		if (!aresetn) begin
			tk_d_r <= 1'b0;
			tc_r <= '0;
			tick_r <= 1'b0;
			ms_now_r <= 16'h0000;
			ticks_r <= 16'h0000;
		end else begin
			tk_d_r <= tk_s_r[1];
			tc_r <= tc_nxt;
			tick_r <= tick_nxt;
			ms_now_r <= ms_now_nxt;
			ticks_r <= ticks_nxt;
		end
	end

	// step memory port, shared by scan and bus
	esl_pkg::esl_step_s cur;
	logic [7:0] mem_addr;
	logic [2:0] mem_fwe;
	logic [31:0] s_wdata_r, s_wdata_nxt, rdata_r, rdata_nxt;
	logic [3:0] s_wstrb_r, s_wstrb_nxt;
	esl_step_mem #(.DEPTH(256)) u_mem (
		.aclk(aclk),
		.addr(mem_addr),
		.fwe(mem_fwe),
		.wdata(s_wdata_r[15:0]),
		.rdata(cur)
	);

	// sequencer state
	esl_pkg::esl_seq_e st_r, st_nxt;
	logic [AW-1:0] ax_r, ax_nxt;
	logic [7:0] step_r [NAX];
	logic [7:0] step_nxt [NAX];
	logic [15:0] ext_r [NAX];
	logic [15:0] ext_nxt [NAX];
	logic [15:0] start_r [NAX];
	logic [15:0] start_nxt [NAX];
	logic [NAX-1:0] run_r, run_nxt, ent_r, ent_nxt;
	logic cmd_valid_nxt;
	esl_pkg::esl_cmd_s cmd_nxt;
	logic start_req_r, ext_req_r, start_req_nxt, ext_req_nxt;
	logic [31:0] req_data_r, req_data_nxt;
	logic eval_go, take;
	logic [15:0] base, elapsed;
	always_comb begin
		st_nxt = st_r;
		ax_nxt = ax_r;
		step_nxt = step_r;
		ext_nxt = ext_r;
		start_nxt = start_r;
		run_nxt = run_r;
		ent_nxt = ent_r;
		cmd_valid_nxt = 1'b0;
		cmd_nxt = cmd_out;
		take = 1'b0;
		eval_go = st_r == esl_pkg::ESL_EVAL && run_r[ax_r];
		base = (cur.ltype == `ESL_LT_TICK) ? ticks_r : ms_now_r;
		if (!ent_r[ax_r]) begin
			base = start_r[ax_r];
		end
		elapsed = ((cur.ltype == `ESL_LT_TICK) ? ticks_r : ms_now_r) - base;
		unique case (st_r)
			esl_pkg::ESL_IDLE: begin
				if (tick_r) begin
					ax_nxt = '0;
					st_nxt = esl_pkg::ESL_FETCH;
				end
			end
			esl_pkg::ESL_FETCH: begin
				st_nxt = esl_pkg::ESL_EVAL;
			end
			esl_pkg::ESL_EVAL: begin
				if (eval_go) begin
					if (ent_r[ax_r]) begin
						ent_nxt[ax_r] = 1'b0;
						start_nxt[ax_r] = base;
						if (cur.cmd[7:0] != `ESL_CMD_NONE) begin
							cmd_valid_nxt = 1'b1;
							cmd_nxt.code = cur.cmd[7:0];
							cmd_nxt.axes = (cur.cmd[15:8] == `ESL_SEL_DEFAULT) ? onehot8(ax_r) : cur.cmd[15:8];
						end
					end
					unique case (cur.ltype)
						`ESL_LT_END: run_nxt[ax_r] = 1'b0;
						`ESL_LT_SYNC: begin
							if (cur.lval != ext_r[ax_r]) begin
								ext_nxt[ax_r] = cur.lval;
								take = 1'b1;
							end
						end
						`ESL_LT_MS: take = elapsed >= cur.lval;
						`ESL_LT_TICK: take = en_s_r[1] && elapsed >= cur.lval;
						default: take = 1'b0;
					endcase
					if (take) begin
						step_nxt[ax_r] = cur.lnext;
						ent_nxt[ax_r] = 1'b1;
					end
				end
				// one evaluation per axis per tick
				if (ax_r == AW'(NAX - 1)) begin
					st_nxt = esl_pkg::ESL_IDLE;
				end else begin
					ax_nxt = ax_r + AW'(1);
					st_nxt = esl_pkg::ESL_FETCH;
				end
			end
		endcase
		// software requests land after evaluation so they win
		if (start_req_r) begin
			run_nxt[AW'(req_data_r[`ESL_CTRL_AXIS])] = !req_data_r[`ESL_CTRL_STOP];
			step_nxt[AW'(req_data_r[`ESL_CTRL_AXIS])] = req_data_r[`ESL_CTRL_STEP];
			ent_nxt[AW'(req_data_r[`ESL_CTRL_AXIS])] = 1'b1;
		end
		if (ext_req_r) begin
			ext_nxt[AW'(req_data_r[`ESL_EXT_AXIS])] = req_data_r[`ESL_EXT_VAL];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= esl_pkg::ESL_IDLE;
			ax_r <= '0;
			run_r <= '0;
			ent_r <= '0;
			cmd_valid <= 1'b0;
			cmd_out <= '0;
			for (int i = 0; i < NAX; i++) begin
				step_r[i] <= 8'h00;
				ext_r[i] <= 16'h0000;
				start_r[i] <= 16'h0000;
			end
		end else begin
			st_r <= st_nxt;
			ax_r <= ax_nxt;
			run_r <= run_nxt;
			ent_r <= ent_nxt;
			cmd_valid <= cmd_valid_nxt;
			cmd_out <= cmd_nxt;
			step_r <= step_nxt;
			ext_r <= ext_nxt;
			start_r <= start_nxt;
		end
	end
	assign running = run_r;

	// axi4-lite slave; table access only while the scan is idle
	logic aw_have_r, w_have_r, ar_have_r, rd_pend_r, bvalid_r, rvalid_r;
	logic aw_have_nxt, w_have_nxt, ar_have_nxt, rd_pend_nxt, bvalid_nxt, rvalid_nxt;
	logic [12:0] s_awaddr_r, s_awaddr_nxt, s_araddr_r, s_araddr_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic grant, wr_go;
	always_comb begin
		aw_have_nxt = aw_have_r;
		w_have_nxt = w_have_r;
		ar_have_nxt = ar_have_r;
		rd_pend_nxt = 1'b0;
		bvalid_nxt = bvalid_r && !s_axi_bready;
		rvalid_nxt = rvalid_r && !s_axi_rready;
		s_awaddr_nxt = s_awaddr_r;
		s_araddr_nxt = s_araddr_r;
		s_wdata_nxt = s_wdata_r;
		s_wstrb_nxt = s_wstrb_r;
		rdata_nxt = rdata_r;
		bresp_nxt = bresp_r;
		rresp_nxt = rresp_r;
		start_req_nxt = 1'b0;
		ext_req_nxt = 1'b0;
		req_data_nxt = req_data_r;
		mem_fwe = 3'b000;
		mem_addr = step_r[ax_r];
		grant = st_r == esl_pkg::ESL_IDLE && !tick_r;
		wr_go = 1'b0;
		// items move only at the edge where valid and ready are both high
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_nxt = 1'b1;
			s_awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_nxt = 1'b1;
			s_wdata_nxt = s_axi_wdata;
			s_wstrb_nxt = s_axi_wstrb;
		end
		if (aw_have_r && w_have_r && !bvalid_r && (grant || !tbl_hit(s_awaddr_r))) begin
			wr_go = 1'b1;
			aw_have_nxt = 1'b0;
			w_have_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = `ESL_RESP_OKAY;
			req_data_nxt = s_wdata_r;
			if (tbl_hit(s_awaddr_r) && s_awaddr_r[3:2] != 2'h3) begin
				mem_addr = tbl_step(s_awaddr_r);
				mem_fwe = (s_wstrb_ok(s_wstrb_r)) ? 3'(3'b001 << s_awaddr_r[3:2]) : 3'b000;
			end else if (s_awaddr_r == `ESL_OFF_CTRL) begin
				start_req_nxt = s_wdata_r[`ESL_CTRL_GO];
			end else if (s_awaddr_r == `ESL_OFF_EXT) begin
				ext_req_nxt = 1'b1;
			end else begin
				bresp_nxt = `ESL_RESP_SLVERR;
			end
		end
		if (s_axi_arvalid && s_axi_arready) begin
			ar_have_nxt = 1'b1;
			s_araddr_nxt = s_axi_araddr;
		end
		if (rd_pend_r) begin
			rvalid_nxt = 1'b1;
			unique case (s_araddr_r[3:2])
				`ESL_FLD_CMD: rdata_nxt = {16'h0000, cur.cmd};
				`ESL_FLD_LINK: rdata_nxt = {16'h0000, cur.ltype, cur.lnext};
				`ESL_FLD_VAL: rdata_nxt = {16'h0000, cur.lval};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end else if (ar_have_r && !rvalid_r) begin
			rresp_nxt = `ESL_RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			if (tbl_hit(s_araddr_r) && s_araddr_r[3:2] != 2'h3) begin
				if (grant && !wr_go) begin
					mem_addr = tbl_step(s_araddr_r);
					rd_pend_nxt = 1'b1;
					ar_have_nxt = 1'b0;
				end
			end else begin
				ar_have_nxt = 1'b0;
				rvalid_nxt = 1'b1;
				if (s_araddr_r == `ESL_OFF_RUN) begin
					rdata_nxt = 32'(run_r);
				end else if (s_araddr_r >= `ESL_OFF_AXIS && s_araddr_r < `ESL_OFF_AXIS_END
					&& 32'(s_araddr_r[4:2]) < NAX) begin
					rdata_nxt = {ext_r[AW'(s_araddr_r[4:2])], 7'h00, run_r[AW'(s_araddr_r[4:2])],
						step_r[AW'(s_araddr_r[4:2])]};
				end else if (s_araddr_r != `ESL_OFF_CTRL && s_araddr_r != `ESL_OFF_EXT) begin
					rresp_nxt = `ESL_RESP_SLVERR;
				end
			end
		end
		if (st_r != esl_pkg::ESL_IDLE) begin
			mem_addr = step_r[ax_r];
		end
	end
	function automatic logic s_wstrb_ok(input logic [3:0] s);
		return s[1:0] == 2'b11;
	endfunction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			ar_have_r <= 1'b0;
			rd_pend_r <= 1'b0;
			bvalid_r <= 1'b0;
			rvalid_r <= 1'b0;
			s_awaddr_r <= 13'h0000;
			s_araddr_r <= 13'h0000;
			s_wdata_r <= 32'h0000_0000;
			s_wstrb_r <= 4'h0;
			rdata_r <= 32'h0000_0000;
			bresp_r <= `ESL_RESP_OKAY;
			rresp_r <= `ESL_RESP_OKAY;
			start_req_r <= 1'b0;
			ext_req_r <= 1'b0;
			req_data_r <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			aw_have_r <= aw_have_nxt;
			w_have_r <= w_have_nxt;
			ar_have_r <= ar_have_nxt;
			rd_pend_r <= rd_pend_nxt;
			bvalid_r <= bvalid_nxt;
			rvalid_r <= rvalid_nxt;
			s_awaddr_r <= s_awaddr_nxt;
			s_araddr_r <= s_araddr_nxt;
			s_wdata_r <= s_wdata_nxt;
			s_wstrb_r <= s_wstrb_nxt;
			rdata_r <= rdata_nxt;
			bresp_r <= bresp_nxt;
			rresp_r <= rresp_nxt;
			start_req_r <= start_req_nxt;
			ext_req_r <= ext_req_nxt;
			req_data_r <= req_data_nxt;
			// ready is a one-cycle take pulse so each item moves once
			s_axi_awready <= s_axi_awvalid && !aw_have_r && !bvalid_r && !s_axi_awready;
			s_axi_wready <= s_axi_wvalid && !w_have_r && !bvalid_r && !s_axi_wready;
			s_axi_arready <= s_axi_arvalid && !ar_have_r && !rvalid_r && !rd_pend_r && !s_axi_arready;
		end
	end
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// assertions
	logic [7:0] cur_step;
	assign cur_step = step_r[ax_r];
	logic quiet;
	assign quiet = !start_req_r && !ext_req_r;
	end_stops_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && quiet && cur.ltype == `ESL_LT_END |=> !run_r[$past(ax_r)]) else $error("end link did not stop");
	sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && quiet && cur.ltype == `ESL_LT_SYNC && cur.lval == ext_r[ax_r]
		|=> step_r[$past(ax_r)] == $past(cur_step)) else $error("equal trigger moved on");
	sync_take_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && quiet && cur.ltype == `ESL_LT_SYNC && cur.lval != ext_r[ax_r]
		|=> ext_r[$past(ax_r)] == $past(cur.lval) && step_r[$past(ax_r)] == $past(cur.lnext))
		else $error("differing trigger not taken");
	default_axis_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && ent_r[ax_r] && cur.cmd[15:8] == `ESL_SEL_DEFAULT && cur.cmd[7:0] != `ESL_CMD_NONE
		|=> cmd_valid && cmd_out.axes == onehot8($past(ax_r))) else $error("default axis wrong");
	sel_axes_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && ent_r[ax_r] && cur.cmd[15:8] != `ESL_SEL_DEFAULT && cur.cmd[7:0] != `ESL_CMD_NONE
		|=> cmd_valid && cmd_out.axes == $past(cur.cmd[15:8])) else $error("selected axes wrong");
	ms_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && quiet && ent_r[ax_r] && cur.ltype == `ESL_LT_MS && cur.lval == 16'h0000
		|=> step_r[$past(ax_r)] == $past(cur.lnext)) else $error("zero delay waited");
	ms_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && quiet && !ent_r[ax_r] && cur.ltype == `ESL_LT_MS && ms_now_r - start_r[ax_r] < cur.lval
		|=> step_r[$past(ax_r)] == $past(cur_step) && !ent_r[$past(ax_r)]) else $error("delay ended early");
	tick_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		eval_go && quiet && cur.ltype == `ESL_LT_TICK && !en_s_r[1]
		|=> step_r[$past(ax_r)] == $past(cur_step)) else $error("tick delay without counter");
	scan_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_r == esl_pkg::ESL_IDLE && tick_r |=> st_r == esl_pkg::ESL_FETCH && ax_r == '0 ##1
		st_r == esl_pkg::ESL_EVAL) else $error("scan did not start");
	ext_reset_a: assert property (@(posedge aclk)
		!aresetn |=> ext_r[0] == 16'h0000) else $error("extended value not cleared");
	sync_cov: cover property (@(posedge aclk) disable iff (!aresetn)
		eval_go && cur.ltype == `ESL_LT_SYNC && cur.lval != ext_r[ax_r]);
	ms_cov: cover property (@(posedge aclk) disable iff (!aresetn)
		eval_go && !ent_r[ax_r] && cur.ltype == `ESL_LT_MS && take);
	end_cov: cover property (@(posedge aclk) disable iff (!aresetn) eval_go && cur.ltype == `ESL_LT_END);
endmodule
`default_nettype wire

// file: bench/esl_plc_model.sv
// communications master model: axi4-lite access to the sequencer
`timescale 1ns/10ps
`default_nettype none
module esl_plc_model (
	// clock
	input wire logic aclk,
	// write channels
	output logic [12:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// read channels
	output logic [12:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 13'h1FFF;
		awvalid = 1'b0;
		wdata = 32'hFFFFFFFF;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 13'h1FFF;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	// payload is inverted on release so a stale value never looks valid
	task automatic wr(input logic [12:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench for the event step sequencer
`timescale 1ns/10ps
`default_nettype none
`include "esl_regs.svh"
module tb;
	localparam int MS = 20;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic cnt_tick_pin = 1'b0;
	logic cnt_enable_pin = 1'b0;
	logic [12:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic cmd_valid;
	esl_pkg::esl_cmd_s cmd_out;
	logic [7:0] running;
	esl_pkg::esl_cmd_s cmds[$];
	int mismatches = 0;
	int n_compared = 0;
	always #4 aclk = ~aclk;
	esl_sequencer #(.NAX(8), .MS_CYCLES(MS)) esl_sequencer_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cnt_tick_pin(cnt_tick_pin), .cnt_enable_pin(cnt_enable_pin),
		.cmd_valid(cmd_valid), .cmd_out(cmd_out), .running(running));
	esl_plc_model esl_plc_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));
	// command pulses last one cycle, so they are collected at every edge
	always @(posedge aclk) begin
		if (cmd_valid === 1'b1) begin
			cmds.push_back(cmd_out);
		end
	end
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [12:0] ta(input logic [7:0] s, input logic [1:0] f);
		return `ESL_OFF_TABLE + 13'(s) * 13'h010 + 13'(f) * 13'h004;
	endfunction
	task automatic wr_ok(input logic [12:0] a, input logic [31:0] d);
		logic [1:0] r;
		esl_plc_model_i.wr(a, d, r);
		chk("bresp", 32'(`ESL_RESP_OKAY), 32'(r));
	endtask
	task automatic rd_chk(input string what, input logic [12:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		esl_plc_model_i.rd(a, d, r);
		chk("rresp", 32'(`ESL_RESP_OKAY), 32'(r));
		chk(what, exp, d);
	endtask
	task automatic prog(input logic [7:0] s, input logic [15:0] c, input logic [7:0] lt,
			input logic [7:0] nx, input logic [15:0] lv);
		wr_ok(ta(s, `ESL_FLD_CMD), {16'h0000, c});
		wr_ok(ta(s, `ESL_FLD_LINK), {16'h0000, lt, nx});
		wr_ok(ta(s, `ESL_FLD_VAL), {16'h0000, lv});
	endtask
	// counter pulses are wide enough for the two-stage pin synchroniser
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge aclk) cnt_tick_pin <= 1'b1;
			repeat (3) @(posedge aclk);
			cnt_tick_pin <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask
	task automatic wait_cy(input int n);
		repeat (n) @(posedge aclk);
	endtask
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		wait_cy(2);
		aresetn <= 1'b1;
		cnt_enable_pin <= 1'b1;
		rd_chk("run mask", `ESL_OFF_RUN, 32'h00000000);
		rd_chk("axis0 ext", `ESL_OFF_AXIS, 32'h00000000);
		esl_plc_model_i.rd(ta(8'h05, 2'h3), d, r);
		chk("unmapped rresp", 32'(`ESL_RESP_SLVERR), 32'(r));
		esl_plc_model_i.wr(ta(8'h05, 2'h3), 32'h12345678, r);
		chk("unmapped bresp", 32'(`ESL_RESP_SLVERR), 32'(r));
		prog(8'h05, 16'h0000, `ESL_LT_MS, 8'hFF, 16'hFFFF);
		rd_chk("full link value", ta(8'h05, `ESL_FLD_VAL), 32'h0000FFFF);
		prog(8'h00, 16'h0000, `ESL_LT_END, 8'h00, 16'h0000);
		prog(8'h01, 16'h0005, `ESL_LT_MS, 8'h02, 16'h0000);
		prog(8'h02, 16'h0306, `ESL_LT_SYNC, 8'h03, 16'h0000);
		prog(8'h03, 16'h0000, `ESL_LT_TICK, 8'h04, 16'h0003);
		prog(8'h04, 16'h0000, `ESL_LT_MS, 8'h00, 16'h0004);
		rd_chk("link word", ta(8'h02, `ESL_FLD_LINK), 32'h00004303);
		wr_ok(`ESL_OFF_CTRL, 32'h80000101);
		wait_cy(5 * MS);
		rd_chk("axis1 at trigger", `ESL_OFF_AXIS + 13'h004, 32'h00000102);
		wait_cy(3 * MS);
		rd_chk("axis1 still waits", `ESL_OFF_AXIS + 13'h004, 32'h00000102);
		wr_ok(`ESL_OFF_EXT, 32'h00050001);
		wait_cy(3 * MS);
		rd_chk("axis1 after trigger", `ESL_OFF_AXIS + 13'h004, 32'h00000103);
		pulses(2);
		wait_cy(3 * MS);
		rd_chk("axis1 two ticks", `ESL_OFF_AXIS + 13'h004, 32'h00000103);
		// a tick with the counter disabled must neither count nor release the step
		cnt_enable_pin <= 1'b0;
		pulses(1);
		wait_cy(3 * MS);
		rd_chk("axis1 counter off", `ESL_OFF_AXIS + 13'h004, 32'h00000103);
		cnt_enable_pin <= 1'b1;
		pulses(1);
		wait_cy(3 * MS);
		rd_chk("axis1 three ticks", `ESL_OFF_AXIS + 13'h004, 32'h00000104);
		rd_chk("run mask busy", `ESL_OFF_RUN, 32'h00000002);
		chk("running busy", 32'h00000002, 32'(running));
		wait_cy(6 * MS);
		rd_chk("run mask ended", `ESL_OFF_RUN, 32'h00000000);
		chk("running ended", 32'h00000000, 32'(running));
		chk("command count", 32'h00000002, 32'(cmds.size()));
		if (cmds.size() == 2) begin
			chk("default axes cmd", 32'h00000205, 32'(cmds[0]));
			chk("selected axes cmd", 32'h00000306, 32'(cmds[1]));
		end
		finish_test();
	end
	initial begin
		wait_cy(20000);
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
